// file: rtl/cca_top.sv
// The register addresses and the strobed register port were decided locally.
module cca_top
  import cca_pkg::*;
#(
  parameter int unsigned TICKS      = cca_pkg::TICKS_PER_SEC,
  parameter bit          HAS_BACKUP = 1'b0
) (
  input  wire logic                      clock,
  input  wire logic                      resetn,
  input  wire logic                      clk_en,
  input  wire logic                      main_power_ok,
  input  wire logic [cca_pkg::ADDR_W-1:0] addr,
  input  wire logic [cca_pkg::DATA_W-1:0] wdata,
  input  wire logic                      wr,
  input  wire logic                      rd,
  output logic      [cca_pkg::DATA_W-1:0] rdata_q,
  output logic                           op_error_q
);
  import cca_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  cca_cal_t  cal_q,   cal_d;
  cca_cal_t  snap_q,  snap_d;
  cca_cal_t  stage_q, stage_d;
  logic      century_q, century_d;
  logic      round_q,   round_d;
  logic      round_prev_q, round_prev_d;
  logic      err_q,  err_d;
  logic      hold_q, hold_d;
  cca_word_t ecode_q, ecode_d;
  cca_word_t rdata_d;

  logic      tick;
  logic      run;
  logic      sel_live, sel_snap, sel_stage;
  logic [2:0] fidx;
  logic      ctrl_wr, rd_op, wr_op, live_wr;
  logic      round_edge;
  logic      err_evt;
  logic      inc_min, inc_hour, inc_day, inc_mon, inc_year;
  cca_cal_t  view;

  cca_if chk_if ();

  // ----------------------------------------------------------------
  // time base and range checker
  // ----------------------------------------------------------------
  if (DATA_W < 12) begin : g_width_bad
    $error("cca_top: DATA_W too narrow for year view");
  end

  // calendar state has no power-dependent clear; only the counter halts
  assign run = main_power_ok | HAS_BACKUP;

  cca_tick #(
    .TICKS (TICKS)
  ) u_tick (
    .clock  (clock),
    .resetn (resetn),
    .clk_en (clk_en),
    .run    (run),
    .tick_q (tick)
  );

  assign chk_if.raw = stage_q;

  cca_check u_check (
    .chk (chk_if.check)
  );

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  assign fidx      = addr[2:0];
  assign sel_live  = (addr[4:3] == A_LIVE[4:3])  && (fidx != 3'h7);
  assign sel_snap  = (addr[4:3] == A_SNAP[4:3])  && (fidx != 3'h7);
  assign sel_stage = (addr[4:3] == A_STAGE[4:3]) && (fidx != 3'h7);
  assign ctrl_wr   = wr && (addr == A_CTRL);
  assign rd_op     = ctrl_wr && wdata[CTRL_RDOP];
  assign wr_op     = ctrl_wr && wdata[CTRL_WROP];
  assign live_wr   = wr && sel_live;

  // ----------------------------------------------------------------
  // year view
  // ----------------------------------------------------------------
  always_comb begin
    view = cal_q;
    if (century_q) begin
      view[F_YEAR] = cal_q[F_YEAR] + CENTURY_BASE;
    end
  end

  // ----------------------------------------------------------------
  // control register and trigger edge
  // ----------------------------------------------------------------
  always_comb begin
    century_d    = century_q;
    round_d      = round_q;
    round_prev_d = round_q;
    if (ctrl_wr) begin
      century_d = wdata[CTRL_CENTURY];
      round_d   = wdata[CTRL_ROUND];
    end
  end

  // only an off-to-on change acts; holding the bit set does nothing more
  assign round_edge = round_q && !round_prev_q;

  // ----------------------------------------------------------------
  // calendar counter
  // ----------------------------------------------------------------
  // priority: write operation, then direct field write, then rounding,
  // then the second tick. a tick landing on a rounding cycle is absorbed.
  always_comb begin
    cal_d    = cal_q;
    inc_min  = 1'b0;
    inc_hour = 1'b0;
    inc_day  = 1'b0;
    inc_mon  = 1'b0;
    inc_year = 1'b0;

    if (round_edge) begin
      cal_d[F_SEC] = 16'h0000;
      inc_min      = (cal_q[F_SEC] >= HALF_MINUTE);
    end else if (tick) begin
      if (cal_q[F_SEC] >= field_max(F_SEC)) begin
        cal_d[F_SEC] = field_min(F_SEC);
        inc_min      = 1'b1;
      end else begin
        cal_d[F_SEC] = cal_q[F_SEC] + 16'h0001;
      end
    end

    if (inc_min) begin
      if (cal_q[F_MIN] >= field_max(F_MIN)) begin
        cal_d[F_MIN] = field_min(F_MIN);
        inc_hour     = 1'b1;
      end else begin
        cal_d[F_MIN] = cal_q[F_MIN] + 16'h0001;
      end
    end

    if (inc_hour) begin
      if (cal_q[F_HOUR] >= field_max(F_HOUR)) begin
        cal_d[F_HOUR] = field_min(F_HOUR);
        inc_day       = 1'b1;
      end else begin
        cal_d[F_HOUR] = cal_q[F_HOUR] + 16'h0001;
      end
    end

    if (inc_day) begin
      if (cal_q[F_WDAY] >= field_max(F_WDAY)) begin
        cal_d[F_WDAY] = field_min(F_WDAY);
      end else begin
        cal_d[F_WDAY] = cal_q[F_WDAY] + 16'h0001;
      end
      if (cal_q[F_DAY] >= days_in_month(cal_q[F_MON], cal_q[F_YEAR])) begin
        cal_d[F_DAY] = field_min(F_DAY);
        inc_mon      = 1'b1;
      end else begin
        cal_d[F_DAY] = cal_q[F_DAY] + 16'h0001;
      end
    end

    if (inc_mon) begin
      if (cal_q[F_MON] >= field_max(F_MON)) begin
        cal_d[F_MON] = field_min(F_MON);
        inc_year     = 1'b1;
      end else begin
        cal_d[F_MON] = cal_q[F_MON] + 16'h0001;
      end
    end

    if (inc_year) begin
      if (cal_q[F_YEAR] >= field_max(F_YEAR)) begin
        cal_d[F_YEAR] = field_min(F_YEAR);
      end else begin
        cal_d[F_YEAR] = cal_q[F_YEAR] + 16'h0001;
      end
    end

    if (live_wr) begin
      if (field_ok(int'(fidx), wdata)) begin
        cal_d[fidx] = wdata;
      end else begin
        cal_d[fidx] = field_min(int'(fidx));
      end
    end

    // year is taken as two digits whatever the view mode
    if (wr_op) begin
      cal_d = chk_if.fixed;
    end
  end

  // ----------------------------------------------------------------
  // snapshot and staging words
  // ----------------------------------------------------------------
  always_comb begin
    snap_d  = snap_q;
    stage_d = stage_q;
    if (rd_op) begin
      snap_d = view;
    end
    if (wr && sel_stage) begin
      stage_d[fidx] = wdata;
    end
  end

  // ----------------------------------------------------------------
  // error reporting
  // ----------------------------------------------------------------
  assign err_evt = (wr_op && (chk_if.bad != '0)) ||
                   (live_wr && !field_ok(int'(fidx), wdata));

  // a new error wins over a same-cycle clear
  always_comb begin
    err_d   = err_q;
    hold_d  = hold_q;
    ecode_d = ecode_q;
    if (wr && (addr == A_STAT)) begin
      err_d  = err_q  && !wdata[STAT_ERR];
      hold_d = hold_q && !wdata[STAT_HOLD];
    end
    if (wr && (addr == A_ECODE)) begin
      ecode_d = wdata;
    end
    if (err_evt) begin
      err_d   = 1'b1;
      hold_d  = 1'b1;
      ecode_d = ERR_CODE_RANGE;
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always_comb begin
    rdata_d = '0;
    if (rd) begin
      if (sel_live) begin
        rdata_d = view[fidx];
      end else if (sel_snap) begin
        rdata_d = snap_q[fidx];
      end else if (sel_stage) begin
        rdata_d = stage_q[fidx];
      end else if (addr == A_CTRL) begin
        rdata_d[CTRL_CENTURY] = century_q;
        rdata_d[CTRL_ROUND]   = round_q;
      end else if (addr == A_STAT) begin
        rdata_d[STAT_ERR]  = err_q;
        rdata_d[STAT_HOLD] = hold_q;
      end else if (addr == A_ECODE) begin
        rdata_d = ecode_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < NFIELD; i++) begin
        cal_q[i]   <= field_min(i);
        snap_q[i]  <= 16'h0000;
        stage_q[i] <= 16'h0000;
      end
      century_q    <= RST_CTRL_BIT;
      round_q      <= RST_CTRL_BIT;
      round_prev_q <= RST_CTRL_BIT;
      err_q        <= 1'b0;
      hold_q       <= 1'b0;
      ecode_q      <= RST_ECODE;
      rdata_q      <= '0;
      op_error_q   <= 1'b0;
    end else if (clk_en) begin
      cal_q        <= cal_d;
      snap_q       <= snap_d;
      stage_q      <= stage_d;
      century_q    <= century_d;
      round_q      <= round_d;
      round_prev_q <= round_prev_d;
      err_q        <= err_d;
      hold_q       <= hold_d;
      ecode_q      <= ecode_d;
      rdata_q      <= rdata_d;
      op_error_q   <= err_d;
    end
  end

endmodule : cca_top

// file: rtl/cca_pkg.sv
package cca_pkg;

  // ----------------------------------------------------------------
  // bus shape
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W  = 16;
  localparam int unsigned ADDR_W  = 5;
  localparam int unsigned NFIELD  = 7;

  typedef logic [DATA_W-1:0]        cca_word_t;
  typedef logic [NFIELD-1:0][15:0]  cca_cal_t;

  // ----------------------------------------------------------------
  // field order, shared by live, snapshot and staging blocks
  // ----------------------------------------------------------------
  localparam int F_YEAR  = 0;
  localparam int F_WDAY  = 1;
  localparam int F_MON   = 2;
  localparam int F_DAY   = 3;
  localparam int F_HOUR  = 4;
  localparam int F_MIN   = 5;
  localparam int F_SEC   = 6;

  // ----------------------------------------------------------------
  // word addresses
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] A_LIVE  = 5'h00;
  localparam logic [ADDR_W-1:0] A_CTRL  = 5'h07;
  localparam logic [ADDR_W-1:0] A_STAT  = 5'h08;
  localparam logic [ADDR_W-1:0] A_ECODE = 5'h09;
  localparam logic [ADDR_W-1:0] A_SNAP  = 5'h10;
  localparam logic [ADDR_W-1:0] A_STAGE = 5'h18;

  // ----------------------------------------------------------------
  // bit positions
  // ----------------------------------------------------------------
  localparam int CTRL_CENTURY = 0;
  localparam int CTRL_ROUND   = 1;
  localparam int CTRL_RDOP    = 2;
  localparam int CTRL_WROP    = 3;
  localparam int STAT_ERR     = 0;
  localparam int STAT_HOLD    = 1;

  // ----------------------------------------------------------------
  // values
  // ----------------------------------------------------------------
  localparam logic [15:0] ERR_CODE_RANGE = 16'h0e1a;
  localparam logic [15:0] CENTURY_BASE   = 16'h07d0;
  localparam logic [15:0] HALF_MINUTE    = 16'h001e;
  localparam logic [15:0] RST_ECODE      = 16'h0000;
  localparam logic        RST_CTRL_BIT   = 1'b0;

  // ----------------------------------------------------------------
  // time base
  // ----------------------------------------------------------------
  localparam longint SECOND_NS    = 1000000000;
  localparam longint CLK_PERIOD_NS = 5;
  localparam int unsigned TICKS_PER_SEC = int'(SECOND_NS / CLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // field limits
  // ----------------------------------------------------------------
  function automatic logic [15:0] field_min(input int i);
    case (i)
      F_WDAY, F_MON, F_DAY: field_min = 16'h0001;
      default:              field_min = 16'h0000;
    endcase
  endfunction : field_min

  function automatic logic [15:0] field_max(input int i);
    case (i)
      F_YEAR:  field_max = 16'h0063;
      F_WDAY:  field_max = 16'h0007;
      F_MON:   field_max = 16'h000c;
      F_DAY:   field_max = 16'h001f;
      F_HOUR:  field_max = 16'h0017;
      default: field_max = 16'h003b;
    endcase
  endfunction : field_max

  function automatic logic field_ok(input int i, input logic [15:0] v);
    field_ok = (v >= field_min(i)) && (v <= field_max(i));
  endfunction : field_ok

  // years 2000..2099: every fourth year is a leap year
  function automatic logic [15:0] days_in_month(input logic [15:0] mon,
                                                input logic [15:0] yr);
    case (mon)
      16'h0004, 16'h0006, 16'h0009, 16'h000b: days_in_month = 16'h001e;
      16'h0002: days_in_month = (yr[1:0] == 2'b00) ? 16'h001d : 16'h001c;
      default:  days_in_month = 16'h001f;
    endcase
  endfunction : days_in_month

endpackage : cca_pkg

// file: rtl/cca_if.sv
interface cca_if;
  import cca_pkg::*;
  cca_cal_t          raw;
  cca_cal_t          fixed;
  logic [NFIELD-1:0] bad;
  modport src   (output raw, input  fixed, input  bad);
  modport check (input  raw, output fixed, output bad);
endinterface : cca_if

// file: rtl/cca_check.sv
module cca_check (
  cca_if.check chk
);
  import cca_pkg::*;

  // out-of-range fields fall back to their smallest legal value
  always_comb begin
    for (int i = 0; i < NFIELD; i++) begin
      chk.bad[i]   = !field_ok(i, chk.raw[i]);
      chk.fixed[i] = chk.bad[i] ? field_min(i) : chk.raw[i];
    end
  end

endmodule : cca_check

// file: rtl/cca_tick.sv
module cca_tick #(
  parameter int unsigned TICKS = cca_pkg::TICKS_PER_SEC
) (
  input  wire logic clock,
  input  wire logic resetn,
  input  wire logic clk_en,
  input  wire logic run,
  output logic      tick_q
);
  import cca_pkg::*;

  localparam int unsigned CW = (TICKS > 2) ? $clog2(TICKS) : 1;
  localparam logic [CW-1:0] LAST = CW'(TICKS - 1);

  // refused at elaboration: a one-clock second cannot be counted down
  if (TICKS < 2) begin : g_ticks_bad
    $error("cca_tick: TICKS must be at least 2");
  end

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic          tick_d;

  // halted counter keeps its phase so a restart resumes mid-second
  always_comb begin
    cnt_d  = cnt_q;
    tick_d = 1'b0;
    if (run) begin
      if (cnt_q == LAST) begin
        cnt_d  = '0;
        tick_d = 1'b1;
      end else begin
        cnt_d = cnt_q + CW'(1);
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else if (clk_en) begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

endmodule : cca_tick

// file: testbench/cca_props.sv
module cca_props
  import cca_pkg::*;
#(
  parameter int unsigned TICKS = 8
) (
  input wire logic                       clock,
  input wire logic                       resetn,
  input wire logic                       clk_en,
  input wire logic                       main_power_ok,
  input wire logic [cca_pkg::ADDR_W-1:0] addr,
  input wire logic [cca_pkg::DATA_W-1:0] wdata,
  input wire logic                       wr,
  input wire logic                       rd,
  input wire logic [cca_pkg::DATA_W-1:0] rdata_q,
  input wire logic                       op_error_q
);
  import cca_pkg::*;
  // ----------------------------------------------------------------
  // century view shadow, the ctrl state that the year checks depend on
  // ----------------------------------------------------------------
  logic cent_q;
  logic cent_d;
  always_comb begin
    cent_d = cent_q;
    if (clk_en && wr && addr == A_CTRL) begin
      cent_d = wdata[CTRL_CENTURY];
    end
  end
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cent_q <= 1'b0;
    end else begin
      cent_q <= cent_d;
    end
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence s_rd(logic [ADDR_W-1:0] a);
    clk_en && rd && addr == a;
  endsequence
  sequence s_wr(logic [ADDR_W-1:0] a);
    clk_en && wr && addr == a;
  endsequence

  chk_rd_idle : assert property (
    clk_en && !rd |=> rdata_q == 16'h0000)
    else $error("read data not zero outside a read");
  chk_year_two : assert property (
    s_rd(A_LIVE) ##0 !cent_q |=> rdata_q <= 16'h0063)
    else $error("plain year out of range");
  chk_year_cent : assert property (
    s_rd(A_LIVE) ##0 cent_q |=> rdata_q >= CENTURY_BASE
      && rdata_q <= CENTURY_BASE + 16'h0063)
    else $error("century year out of range");
  chk_wday_range : assert property (
    s_rd(A_LIVE + 5'h01) |=> rdata_q inside {[16'h0001:16'h0007]})
    else $error("weekday out of range");
  chk_month_range : assert property (
    s_rd(A_LIVE + 5'h02) |=> rdata_q inside {[16'h0001:16'h000c]})
    else $error("month out of range");
  chk_hour_range : assert property (
    s_rd(A_LIVE + 5'h04) |=> rdata_q <= 16'h0017)
    else $error("hour out of range");
  chk_sec_range : assert property (
    s_rd(A_LIVE + 5'h06) |=> rdata_q <= 16'h003b)
    else $error("second out of range");
  chk_err_set : assert property (
    s_wr(A_LIVE + 5'h06) ##0 wdata > 16'h003b |=> op_error_q)
    else $error("bad second did not raise error");
  chk_err_cause : assert property (
    $rose(op_error_q) |-> $past(wr))
    else $error("error raised without a write");
  chk_err_clear : assert property (
    s_wr(A_STAT) ##0 wdata[STAT_ERR] |=> !op_error_q)
    else $error("error flag not cleared");
endmodule : cca_props

bind cca_top cca_props #(.TICKS(TICKS)) i_props (
  .clock        (clock),
  .resetn       (resetn),
  .clk_en       (clk_en),
  .main_power_ok(main_power_ok),
  .addr         (addr),
  .wdata        (wdata),
  .wr           (wr),
  .rd           (rd),
  .rdata_q      (rdata_q),
  .op_error_q   (op_error_q)
);

// file: testbench/calendar_clock_access_tb.sv
module calendar_clock_access_tb
  import cca_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned TICKS = 8;
  typedef logic [15:0] cca_seven_t [7];
  logic              clock = 1'b0;
  logic              resetn;
  logic              clk_en;
  logic              main_power_ok;
  logic              wr;
  logic              rd;
  logic              op_error_q;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata_q;
  int                error_cnt;
  int                total_checks;
  int                cyc = 0;

  // short tick so carries are reachable in a short run
  cca_top #(.TICKS(TICKS), .HAS_BACKUP(1'b0)) i_dut (
    .clock        (clock),
    .resetn       (resetn),
    .clk_en       (clk_en),
    .main_power_ok(main_power_ok),
    .addr         (addr),
    .wdata        (wdata),
    .wr           (wr),
    .rd           (rd),
    .rdata_q      (rdata_q),
    .op_error_q   (op_error_q)
  );

  always #2.5 clock = ~clock;

  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      end_sim();
    end
  end

  // ----------------------------------------------------------------
  // bus and compare tasks
  // ----------------------------------------------------------------
  task automatic chk(input string w, input logic [15:0] s, e);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", w, e, s);
    end
  endtask : chk
  task automatic bus_wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : bus_wr
  task automatic bus_rd(input logic [ADDR_W-1:0] a, output logic [15:0] d);
    @(posedge clock);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    d = rdata_q;
  endtask : bus_rd
  task automatic rd_chk(input string w, input logic [ADDR_W-1:0] a,
                        input logic [15:0] e);
    logic [15:0] d;
    bus_rd(a, d);
    chk(w, d, e);
  endtask : rd_chk
  task automatic load_time(input cca_seven_t v);
    for (int i = 0; i < 7; i++) begin
      bus_wr(A_STAGE + ADDR_W'(i), v[i]);
    end
    bus_wr(A_CTRL, 16'h0008);
  endtask : load_time
  task automatic fields_chk(input logic [ADDR_W-1:0] b, input cca_seven_t v);
    for (int i = 0; i < 7; i++) begin
      rd_chk("calendar field", b + ADDR_W'(i), v[i]);
    end
  endtask : fields_chk

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    fields_chk(A_LIVE, '{0, 1, 1, 1, 0, 0, 0});
    rd_chk("ctrl", A_CTRL, 16'h0000);
    rd_chk("status", A_STAT, 16'h0000);
    rd_chk("error code", A_ECODE, RST_ECODE);
    rd_chk("unmapped", 5'h0a, 16'h0000);
    $display("test reset done");
  endtask : t_reset
  task automatic t_write_read();
    cca_seven_t v = '{16'h0004, 2, 12, 15, 15, 27, 30};
    load_time(v);
    fields_chk(A_LIVE, v);
    bus_wr(A_CTRL, 16'h0004);
    bus_wr(A_SNAP, 16'h0055);
    fields_chk(A_SNAP, v);
    bus_wr(A_CTRL, 16'h0001);
    rd_chk("century year", A_LIVE, 16'h07d4);
    bus_wr(A_CTRL, 16'h0005);
    rd_chk("snapshot year", A_SNAP, 16'h07d4);
    bus_wr(A_LIVE, 16'h0032);
    rd_chk("year 2050", A_LIVE, 16'h0802);
    bus_wr(A_CTRL, 16'h0000);
    rd_chk("plain year", A_LIVE, 16'h0032);
    $display("test write and read done");
  endtask : t_write_read
  task automatic t_round();
    logic [15:0] sec [2] = '{16'h001e, 16'h001d};
    for (int k = 0; k < 2; k++) begin
      bus_wr(A_LIVE + 5'h06, sec[k]);
      bus_wr(A_CTRL, 16'h0000);
      bus_wr(A_CTRL, 16'h0002);
      repeat (2) @(posedge clock);
      rd_chk("rounded second", A_LIVE + 5'h06, 16'h0000);
      rd_chk("rounded minute", A_LIVE + 5'h05, 16'h001c);
    end
    rd_chk("round bit", A_CTRL, 16'h0002);
    // a strobe seen while clk_en is low must leave no trace
    @(posedge clock);
    clk_en <= 1'b0;
    bus_wr(A_LIVE + 5'h05, 16'h0010);
    clk_en <= 1'b1;
    rd_chk("frozen minute", A_LIVE + 5'h05, 16'h001c);
    $display("test round done");
  endtask : t_round
  task automatic t_error();
    load_time('{16'h0004, 2, 13, 15, 15, 27, 60});
    @(negedge clock);
    chk("error pin", {15'h0, op_error_q}, 16'h0001);
    rd_chk("status", A_STAT, 16'h0003);
    rd_chk("error code", A_ECODE, ERR_CODE_RANGE);
    bus_wr(A_ECODE, 16'h0000);
    rd_chk("error code written", A_ECODE, 16'h0000);
    fields_chk(A_LIVE, '{16'h0004, 2, 1, 15, 15, 27, 0});
    bus_wr(A_STAT, 16'h0003);
    rd_chk("status cleared", A_STAT, 16'h0000);
    bus_wr(A_LIVE + 5'h06, 16'h003c);
    @(negedge clock);
    chk("direct error", {15'h0, op_error_q}, 16'h0001);
    rd_chk("second min", A_LIVE + 5'h06, 16'h0000);
    rd_chk("error code again", A_ECODE, ERR_CODE_RANGE);
    bus_wr(A_STAT, 16'h0003);
    $display("test error done");
  endtask : t_error
  task automatic t_count();
    logic [15:0] d = 16'h003b;
    load_time('{16'h0063, 7, 12, 31, 23, 59, 59});
    main_power_ok <= 1'b1;
    for (int n = 0; n < 40 && d !== 16'h0000; n++) begin
      bus_rd(A_LIVE + 5'h06, d);
    end
    @(posedge clock);
    main_power_ok <= 1'b0;
    chk("second wrap", d, 16'h0000);
    repeat (40) @(posedge clock);
    fields_chk(A_LIVE, '{0, 1, 1, 1, 0, 0, 0});
    $display("test count done");
  endtask : t_count

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim

  initial begin
    resetn        = 1'b0;
    clk_en        = 1'b1;
    main_power_ok = 1'b0;
    addr          = '0;
    wdata         = '0;
    wr            = 1'b0;
    rd            = 1'b0;
    error_cnt     = 0;
    total_checks  = 0;
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    t_reset();
    t_write_read();
    t_round();
    t_error();
    t_count();
    end_sim();
  end
endmodule : calendar_clock_access_tb
